/* File: pzsw_top.sv */
// setpoint, wheel and trigger control of the piezo drive unit
`timescale 1ns/1ps
module pzsw_top #(
   parameter int VAL_W = pzsw_pkg::VAL_W
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rstn,
   // register port
   input  wire logic [pzsw_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [pzsw_pkg::DATA_W-1:0]   regWdata,
   input  wire logic                          regWr,
   input  wire logic                          regRd,
   output logic      [pzsw_pkg::DATA_W-1:0]   regRdata,
   // analogue input value and front-panel wheel
   input  wire logic [VAL_W-1:0]              extIn,
   input  wire logic                          wheelClick,
   input  wire logic                          wheelUp,
   // drive outputs
   output logic      [VAL_W-1:0]              driveDemand,
   output logic      [VAL_W-1:0]              feedbackValue,
   output logic                               loopClosed,
   output logic      [7:0]                    loopKp,
   output logic      [7:0]                    loopKi,
   output logic      [1:0]                    inputSel,
   // move starts
   output logic                               moveRelStart,
   output logic                               moveAbsStart,
   output logic                               moveHomeStart,
   // trigger ports, oe low while driving
   input  wire logic                          trigPortAIn,
   output logic                               trigPortAOut,
   output logic                               trigPortAOeN,
   input  wire logic                          trigPortBIn,
   output logic                               trigPortBOut,
   output logic                               trigPortBOeN,
   // non-volatile store, read data one cycle after nvRd
   input  wire logic                          nvHasData,
   input  wire logic [pzsw_pkg::DATA_W-1:0]   nvRdata,
   output logic                               nvRd,
   output logic                               nvWr,
   output logic      [pzsw_pkg::NV_AW-1:0]    nvAddr,
   output logic      [pzsw_pkg::DATA_W-1:0]   nvWdata
);
   // settings
   logic [4:0]       ctrl_r;
   logic [15:0]      loop_r;
   logic [VAL_W-1:0] jog_r;
   logic [VAL_W-1:0] wstep_r;
   logic [4:0]       wheel_r;
   logic [VAL_W-1:0] pre1_r;
   logic [VAL_W-1:0] pre2_r;
   logic [9:0]       trig_r;
   logic [VAL_W-1:0] setpt_r;
   // trigger pipeline
   logic [1:0]       syncA_r;
   logic [1:0]       syncB_r;
   logic [1:0]       actPrev_r;
   logic [1:0]       trigAct;
   logic [1:0]       trigEdge;
   logic [1:0]       trigIsIn;
   logic [2:0]       tmode [2];
   // nv store
   pzsw_pkg::pzsw_nv_e        nvState_r;
   logic [pzsw_pkg::NV_AW-1:0] nvIdx_r;
   logic                      nvLdPend_r;
   logic [pzsw_pkg::NV_AW-1:0] nvLdIdx_r;
   logic                      persistReq;
   // setpoint step
   logic                      stepEn;
   logic                      stepUp;
   logic [VAL_W-1:0]          stepAmt;
   logic [VAL_W-1:0]          setptMax;
   logic                      hostWrSetpt;
   logic                      gotoEn;

   wire logic isClosed = ctrl_r[pzsw_pkg::CTRL_LOOP];
   wire logic wrIdle   = regWr && (nvState_r == pzsw_pkg::NV_IDLE);

   // add with clamp at lim, subtract with floor at 0
   function automatic logic [VAL_W-1:0] satStep(
      input logic [VAL_W-1:0] cur,
      input logic [VAL_W-1:0] amt,
      input logic             up,
      input logic [VAL_W-1:0] lim
   );
      logic [VAL_W:0] sum;
      sum = '0;
      if (up) begin
         sum = {1'b0, cur} + {1'b0, amt};
         satStep = (sum > {1'b0, lim}) ? lim : sum[VAL_W-1:0];
      end else begin
         satStep = (amt > cur) ? '0 : cur - amt;
      end
   endfunction

   // packed image of one settings word, shared by reads and saves
   function automatic logic [pzsw_pkg::DATA_W-1:0] settingWord(
      input logic [pzsw_pkg::NV_AW-1:0] idx
   );
      settingWord = '0;
      unique case (idx)
         3'h0:    settingWord[4:0] = {1'b0, ctrl_r[3:0]};
         3'h1:    settingWord[15:0] = loop_r;
         3'h2:    settingWord[VAL_W-1:0] = jog_r;
         3'h3:    settingWord[4:0] = wheel_r;
         3'h4:    settingWord[VAL_W-1:0] = pre1_r;
         3'h5:    settingWord[VAL_W-1:0] = pre2_r;
         3'h6:    settingWord[9:0] = trig_r;
         default: settingWord[VAL_W-1:0] = wstep_r;
      endcase
   endfunction

   // loop constants and reload of settings
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r  <= '0;
         loop_r  <= {pzsw_pkg::LOOP_DEF, pzsw_pkg::LOOP_DEF};
         jog_r   <= '0;
         wstep_r <= '0;
         wheel_r <= '0;
         pre1_r  <= '0;
         pre2_r  <= '0;
         trig_r  <= '0;
      end else if (nvLdPend_r) begin
         unique case (nvLdIdx_r)
            3'h0:    ctrl_r <= {1'b0, nvRdata[3:0]};
            3'h1:    loop_r <= nvRdata[15:0];
            3'h2:    jog_r <= nvRdata[VAL_W-1:0];
            3'h3:    wheel_r <= nvRdata[4:0];
            3'h4:    pre1_r <= nvRdata[VAL_W-1:0];
            3'h5:    pre2_r <= nvRdata[VAL_W-1:0];
            3'h6:    trig_r <= nvRdata[9:0];
            default: wstep_r <= nvRdata[VAL_W-1:0];
         endcase
      end else if (wrIdle) begin
         // settings written by host at their register offsets
         unique case (regAddr)
            pzsw_pkg::OFS_CTRL:  ctrl_r <= regWdata[4:0];
            pzsw_pkg::OFS_LOOP:  loop_r <= regWdata[15:0];
            pzsw_pkg::OFS_JOG:   jog_r <= regWdata[VAL_W-1:0];
            pzsw_pkg::OFS_WHEEL: wheel_r <= regWdata[4:0];
            pzsw_pkg::OFS_PRE1:  pre1_r <= regWdata[VAL_W-1:0];
            pzsw_pkg::OFS_PRE2:  pre2_r <= regWdata[VAL_W-1:0];
            pzsw_pkg::OFS_TRIG:  trig_r <= regWdata[9:0];
            pzsw_pkg::OFS_WSTEP: wstep_r <= regWdata[VAL_W-1:0];
            default: ;
         endcase
      end else begin
         // persist bit is a request, not a stored setting
         ctrl_r[pzsw_pkg::CTRL_PERS] <= 1'b0;
      end
   end

   assign persistReq = ctrl_r[pzsw_pkg::CTRL_PERS];

   // load words 0 to 6 after reset, save them on request; wstep_r is not stored
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nvState_r  <= pzsw_pkg::NV_LOAD;
         nvIdx_r    <= '0;
         nvRd       <= 1'b0;
         nvWr       <= 1'b0;
         nvAddr     <= '0;
         nvWdata    <= '0;
         nvLdPend_r <= 1'b0;
         nvLdIdx_r  <= '0;
      end else begin
         nvRd       <= 1'b0;
         nvWr       <= 1'b0;
         nvLdPend_r <= nvRd;
         nvLdIdx_r  <= nvAddr;
         unique case (nvState_r)
            pzsw_pkg::NV_LOAD: begin
               // a blank store leaves the reset defaults in place
               if (!nvHasData || nvIdx_r == pzsw_pkg::NV_LAST + 3'h1) begin
                  nvState_r <= pzsw_pkg::NV_IDLE;
                  nvIdx_r   <= '0;
               end else begin
                  nvRd    <= 1'b1;
                  nvAddr  <= nvIdx_r;
                  nvIdx_r <= nvIdx_r + 3'h1;
               end
            end
            pzsw_pkg::NV_IDLE: begin
               if (persistReq) begin
                  nvState_r <= pzsw_pkg::NV_SAVE;
                  nvIdx_r   <= '0;
               end
            end
            pzsw_pkg::NV_SAVE: begin
               nvWr    <= 1'b1;
               nvAddr  <= nvIdx_r;
               nvWdata <= settingWord(nvIdx_r);
               nvIdx_r <= nvIdx_r + 3'h1;
               if (nvIdx_r == pzsw_pkg::NV_LAST) begin
                  nvState_r <= pzsw_pkg::NV_IDLE;
               end
            end
            default: nvState_r <= pzsw_pkg::NV_IDLE;
         endcase
      end
   end

   // two-stage synchronisers, then a third stage for the edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         syncA_r <= 2'b11;
         syncB_r <= 2'b11;
      end else begin
         syncA_r <= {syncA_r[0], trigPortAIn};
         syncB_r <= {syncB_r[0], trigPortBIn};
      end
   end

   assign tmode[0] = trig_r[2:0];
   assign tmode[1] = trig_r[pzsw_pkg::TRG_FLD_W+2:pzsw_pkg::TRG_FLD_W];

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         trigIsIn[i] = tmode[i] != pzsw_pkg::TM_DIGOUT;
      end
      // polarity bit set means active low
      trigAct[0] = syncA_r[1] ^ trig_r[pzsw_pkg::TRG_POL];
      trigAct[1] = syncB_r[1]
                   ^ trig_r[pzsw_pkg::TRG_FLD_W+pzsw_pkg::TRG_POL];
      trigEdge = trigAct & ~actPrev_r & trigIsIn;
   end

   // inputs start high as with the pull-up
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         actPrev_r <= 2'b11;
      end else begin
         actPrev_r <= trigAct;
      end
   end

   // drive only in digital-out mode, level follows polarity
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trigPortAOut <= 1'b1;
         trigPortAOeN <= 1'b1;
         trigPortBOut <= 1'b1;
         trigPortBOeN <= 1'b1;
      end else begin
         trigPortAOeN <= trigIsIn[0];
         trigPortBOeN <= trigIsIn[1];
         trigPortAOut <= trig_r[pzsw_pkg::TRG_DOUT]
                         ^ trig_r[pzsw_pkg::TRG_POL];
         trigPortBOut <= trig_r[pzsw_pkg::TRG_DOUT+1]
                         ^ trig_r[pzsw_pkg::TRG_FLD_W+pzsw_pkg::TRG_POL];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         moveRelStart  <= 1'b0;
         moveAbsStart  <= 1'b0;
         moveHomeStart <= 1'b0;
      end else begin
         moveRelStart  <= 1'b0;
         moveAbsStart  <= 1'b0;
         moveHomeStart <= 1'b0;
         for (int i = 0; i < 2; i++) begin
            if (trigEdge[i] && tmode[i] == pzsw_pkg::TM_RELMOVE) begin
               moveRelStart <= 1'b1;
            end
            if (trigEdge[i] && tmode[i] == pzsw_pkg::TM_ABSMOVE) begin
               moveAbsStart <= 1'b1;
            end
            if (trigEdge[i] && tmode[i] == pzsw_pkg::TM_HOME) begin
               moveHomeStart <= 1'b1;
            end
         end
      end
   end

   // pick one step source per cycle: wheel first, then trigger a, b
   always_comb begin
      stepEn  = 1'b0;
      stepUp  = 1'b0;
      stepAmt = '0;
      gotoEn  = 1'b0;
      hostWrSetpt = wrIdle && regAddr == pzsw_pkg::OFS_SETPT;
      // closed loop limit is full extension
      setptMax = isClosed ? pzsw_pkg::POS_FULL : pzsw_pkg::VOLT_FULL_MV;
      if (wheelClick) begin
         stepUp = wheelUp ^ wheel_r[pzsw_pkg::WH_DIRNEG];
         unique case (wheel_r[1:0])
            pzsw_pkg::WM_ADJUST: begin
               stepEn = 1'b1;
               unique case (wheel_r[pzsw_pkg::WH_GEAR_L+:2])
                  pzsw_pkg::GR_HIGH: stepAmt = pzsw_pkg::GEAR_HIGH_MV;
                  pzsw_pkg::GR_MED:  stepAmt = pzsw_pkg::GEAR_MED_MV;
                  default:           stepAmt = pzsw_pkg::GEAR_LOW_MV;
               endcase
            end
            pzsw_pkg::WM_JOG: begin
               // one jog step per click, unit follows loop mode
               stepEn  = 1'b1;
               stepAmt = jog_r;
            end
            pzsw_pkg::WM_GOTO: gotoEn = 1'b1;
            default: ;
         endcase
      end else begin
         for (int i = 1; i >= 0; i--) begin
            // jog triggers only in open loop
            if (trigEdge[i] && !isClosed
                && (tmode[i] == pzsw_pkg::TM_JOGUP
                    || tmode[i] == pzsw_pkg::TM_JOGDN)) begin
               stepEn  = 1'b1;
               stepUp  = tmode[i] == pzsw_pkg::TM_JOGUP;
               stepAmt = wstep_r;
            end
         end
      end
   end

   // setpoint: host write wins over panel and triggers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         setpt_r <= '0;
      end else if (hostWrSetpt) begin
         setpt_r <= (regWdata[VAL_W-1:0] > setptMax)
                    ? setptMax : regWdata[VAL_W-1:0];
      end else if (gotoEn) begin
         setpt_r <= stepUp ? pre1_r : pre2_r;
      end else if (stepEn) begin
         setpt_r <= satStep(setpt_r, stepAmt, stepUp, setptMax);
      end else if (setpt_r > setptMax) begin
         setpt_r <= setptMax;
      end
   end

   // open loop with CTRL_EXTEN set sums external input, closed loop uses it as feedback
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         driveDemand   <= '0;
         feedbackValue <= '0;
         loopClosed    <= 1'b0;
         loopKp        <= pzsw_pkg::LOOP_DEF;
         loopKi        <= pzsw_pkg::LOOP_DEF;
         inputSel      <= '0;
      end else begin
         loopClosed <= isClosed;
         loopKp     <= loop_r[7:0];
         loopKi     <= loop_r[pzsw_pkg::LOOP_I_L+:8];
         inputSel   <= ctrl_r[pzsw_pkg::CTRL_SRC_L+:2];
         feedbackValue <= isClosed ? extIn : '0;
         if (!isClosed && ctrl_r[pzsw_pkg::CTRL_EXTEN]) begin
            driveDemand <= satStep(setpt_r, extIn, 1'b1,
                                   pzsw_pkg::VOLT_FULL_MV);
         end else begin
            driveDemand <= setpt_r;
         end
      end
   end

   // register reads, unmapped offsets read zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= '0;
      end else if (regRd) begin
         regRdata <= '0;
         unique case (regAddr)
            pzsw_pkg::OFS_CTRL:   regRdata <= settingWord(3'h0);
            pzsw_pkg::OFS_LOOP:   regRdata <= settingWord(3'h1);
            pzsw_pkg::OFS_JOG:    regRdata <= settingWord(3'h2);
            pzsw_pkg::OFS_WHEEL:  regRdata <= settingWord(3'h3);
            pzsw_pkg::OFS_PRE1:   regRdata <= settingWord(3'h4);
            pzsw_pkg::OFS_PRE2:   regRdata <= settingWord(3'h5);
            pzsw_pkg::OFS_TRIG:   regRdata <= settingWord(3'h6);
            pzsw_pkg::OFS_WSTEP:  regRdata <= settingWord(3'h7);
            pzsw_pkg::OFS_STAT:
               regRdata[4:0] <= {nvState_r != pzsw_pkg::NV_IDLE, isClosed,
                                 actPrev_r[1], syncB_r[1], syncA_r[1]};
            pzsw_pkg::OFS_SETPT:  regRdata[VAL_W-1:0] <= setpt_r;
            pzsw_pkg::OFS_DEMAND: regRdata[VAL_W-1:0] <= driveDemand;
            default: ;
         endcase
      end
   end
endmodule

/* File: pzsw_pkg.sv */
// shared constants for the piezo setpoint, wheel and trigger block
package pzsw_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int VAL_W  = 16;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_LOOP   = 8'h04;
   localparam logic [7:0] OFS_JOG    = 8'h08;
   localparam logic [7:0] OFS_WHEEL  = 8'h0C;
   localparam logic [7:0] OFS_PRE1   = 8'h10;
   localparam logic [7:0] OFS_PRE2   = 8'h14;
   localparam logic [7:0] OFS_TRIG   = 8'h18;
   localparam logic [7:0] OFS_STAT   = 8'h1C;
   localparam logic [7:0] OFS_SETPT  = 8'h20;
   localparam logic [7:0] OFS_DEMAND = 8'h24;
   localparam logic [7:0] OFS_WSTEP  = 8'h28;
   // control register fields
   localparam int CTRL_LOOP  = 0;
   localparam int CTRL_EXTEN = 1;
   localparam int CTRL_SRC_L = 2;
   localparam int CTRL_PERS  = 4;
   // loop constant fields and reset value
   localparam int LOOP_I_L = 8;
   localparam logic [7:0] LOOP_DEF = 8'h64;
   // wheel register fields
   localparam int WH_GEAR_L = 2;
   localparam int WH_DIRNEG = 4;
   // trigger register fields: port a in 3:0, port b in 7:4
   localparam int TRG_FLD_W = 4;
   localparam int TRG_POL   = 3;
   localparam int TRG_DOUT  = 8;
   // values in millivolt, position in hundredths of a percent
   localparam logic [15:0] GEAR_HIGH_MV = 16'h03E8;
   localparam logic [15:0] GEAR_MED_MV  = 16'h0064;
   localparam logic [15:0] GEAR_LOW_MV  = 16'h000A;
   localparam logic [15:0] POS_FULL     = 16'h2710;
   localparam logic [15:0] VOLT_FULL_MV = 16'hFFFF;
   // non-volatile store
   localparam int NV_AW = 3;
   localparam logic [2:0] NV_LAST = 3'h6;

   typedef enum logic [1:0] {
      WM_ADJUST = 2'b00,
      WM_JOG    = 2'b01,
      WM_GOTO   = 2'b10
   } pzsw_wmode_e;

   typedef enum logic [1:0] {
      GR_HIGH = 2'b00,
      GR_MED  = 2'b01,
      GR_LOW  = 2'b10
   } pzsw_gear_e;

   typedef enum logic [2:0] {
      TM_OFF     = 3'b000,
      TM_DIGIN   = 3'b001,
      TM_JOGUP   = 3'b010,
      TM_JOGDN   = 3'b011,
      TM_RELMOVE = 3'b100,
      TM_ABSMOVE = 3'b101,
      TM_HOME    = 3'b110,
      TM_DIGOUT  = 3'b111
   } pzsw_tmode_e;

   typedef enum logic [1:0] {
      NV_LOAD = 2'b00,
      NV_IDLE = 2'b01,
      NV_SAVE = 2'b10
   } pzsw_nv_e;
endpackage

/* File: pzsw_sva.sv */
// port assertions for the piezo setpoint, wheel and trigger block
`timescale 1ns/1ps
module pzsw_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // register port
   input wire logic [7:0]  regAddr,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   // drive side
   input wire logic [15:0] extIn,
   input wire logic [15:0] driveDemand,
   input wire logic [15:0] feedbackValue,
   input wire logic        loopClosed,
   input wire logic [7:0]  loopKp,
   input wire logic [7:0]  loopKi,
   // triggers and moves
   input wire logic        moveRelStart,
   input wire logic        moveAbsStart,
   input wire logic        moveHomeStart,
   input wire logic        trigPortAIn,
   input wire logic        trigPortBIn,
   // store port
   input wire logic        nvRd,
   input wire logic        nvWr,
   input wire logic [2:0]  nvAddr
);
   logic       anyMove;
   logic [1:0] pinPrev_r;
   logic [5:0] chgHist_r;
   assign anyMove = moveRelStart | moveAbsStart | moveHomeStart;
   // pin change history, seeded idle like the pull-ups
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pinPrev_r <= 2'b11;
         chgHist_r <= 6'h00;
      end else begin
         pinPrev_r <= {trigPortAIn, trigPortBIn};
         chgHist_r <= {chgHist_r[4:0],
                       {trigPortAIn, trigPortBIn} != pinPrev_r};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_wrStep;
      ##1 nvWr && nvAddr == $past(nvAddr) + 3'h1;
   endsequence
   property p_saveStart;
      $rose(nvWr) |-> nvAddr == 3'h0;
   endproperty
   property p_saveSeq;
      nvWr && nvAddr < 3'h6 |-> s_wrStep;
   endproperty
   property p_saveEnd;
      nvWr && nvAddr == 3'h6 |=> !nvWr;
   endproperty
   property p_loadSeq;
      nvRd && nvAddr < 3'h6 |=> nvRd && nvAddr == $past(nvAddr) + 3'h1;
   endproperty
   property p_loopRead;
      regRd && regAddr == pzsw_pkg::OFS_LOOP
         |=> regRdata == {16'h0000, loopKi, loopKp};
   endproperty
   property p_fbClosed;
      loopClosed |-> feedbackValue == $past(extIn);
   endproperty
   property p_fbOpen;
      !loopClosed |-> feedbackValue == 16'h0000;
   endproperty
   property p_posClamp;
      loopClosed && $past(loopClosed, 3) |-> driveDemand <= 16'h2710;
   endproperty
   property p_onePulse;
      anyMove |=> !anyMove;
   endproperty
   property p_syncDelay;
      anyMove |-> |chgHist_r[4:2];
   endproperty
   a_saveStart: assert property (p_saveStart)
      else $error("save does not start at word 0");
   a_saveSeq: assert property (p_saveSeq)
      else $error("save words not consecutive");
   a_saveEnd: assert property (p_saveEnd)
      else $error("save runs past last word");
   a_loadSeq: assert property (p_loadSeq)
      else $error("load words not consecutive");
   a_loopRead: assert property (p_loopRead)
      else $error("loop constants read back wrong");
   a_fbClosed: assert property (p_fbClosed)
      else $error("feedback not taken from input in closed loop");
   a_fbOpen: assert property (p_fbOpen)
      else $error("feedback not zero in open loop");
   a_posClamp: assert property (p_posClamp)
      else $error("position setpoint above full extension");
   a_onePulse: assert property (p_onePulse)
      else $error("move start longer than one cycle");
   a_syncDelay: assert property (p_syncDelay)
      else $error("move start without synchronised pin edge");
endmodule

/* File: pzsw_nv_model.sv */
// behavioural non-volatile store on the far side of the block
`timescale 1ns/1ps
module pzsw_nv_model (
   // clock
   input wire logic        clk,
   // store port
   input wire logic        nvRd,
   input wire logic        nvWr,
   input wire logic [2:0]  nvAddr,
   input wire logic [31:0] nvWdata,
   output logic            nvHasData,
   output logic [31:0]     nvRdata
);
   logic [31:0] mem [0:6];
   // no reset input: contents must survive the block's reset
   initial begin
      nvHasData = 1'b0;
      nvRdata = 32'h0000_0000;
   end
   always @(posedge clk) begin
      if (nvWr) begin
         mem[nvAddr] <= nvWdata;
         nvHasData <= 1'b1;
      end
   end
   // word one cycle after request, junk when not asked
   always @(posedge clk) begin
      nvRdata <= nvRd ? mem[nvAddr] : ~nvRdata;
   end
endmodule

/* File: pzsw_top_tb.sv */
// self-checking bench for the piezo setpoint, wheel and trigger block
`timescale 1ns/1ps
module pzsw_top_tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [15:0] extIn = 16'h0;
   logic        wheelClick = 1'b0;
   logic        wheelUp = 1'b0;
   logic        drvA = 1'b0, lvlA = 1'b1, drvB = 1'b0, lvlB = 1'b1;
   logic [31:0] regRdata, nvRdata, nvWdata;
   logic [15:0] driveDemand, feedbackValue;
   logic [7:0]  loopKp, loopKi;
   logic [1:0]  inputSel;
   logic [2:0]  nvAddr;
   logic        loopClosed, moveRelStart, moveAbsStart, moveHomeStart;
   logic        trigPortAOut, trigPortAOeN, trigPortBOut, trigPortBOeN;
   logic        nvHasData, nvRd, nvWr;
   wire         pinA, pinB;
   int          bad_count = 0, tests_run = 0, cyc = 0, sp = 0;
   int          moves [3] = '{0, 0, 0};
   int          gearMv [3] = '{1000, 100, 10};
   logic [31:0] rnd = 32'hce9bffda;
   assign pinA = !trigPortAOeN ? trigPortAOut : (drvA ? lvlA : 1'b1);
   assign pinB = !trigPortBOeN ? trigPortBOut : (drvB ? lvlB : 1'b1);
   pzsw_top u_pzsw_top (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .extIn, .wheelClick, .wheelUp, .driveDemand, .feedbackValue,
      .loopClosed, .loopKp, .loopKi, .inputSel, .moveRelStart, .moveAbsStart,
      .moveHomeStart, .trigPortAIn(pinA), .trigPortAOut, .trigPortAOeN,
      .trigPortBIn(pinB), .trigPortBOut, .trigPortBOeN, .nvHasData,
      .nvRdata, .nvRd, .nvWr, .nvAddr, .nvWdata);
   pzsw_nv_model u_pzsw_nv_model (.clk, .nvRd, .nvWr, .nvAddr, .nvWdata,
      .nvHasData, .nvRdata);
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (moveRelStart === 1'b1) moves[0]++;
      if (moveAbsStart === 1'b1) moves[1]++;
      if (moveHomeStart === 1'b1) moves[2]++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int sat(input int v, input int lim);
      return v < 0 ? 0 : (v > lim ? lim : v);
   endfunction
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkPin(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t level %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chkReg(d, exp);
   endtask
   task automatic doReset();
      logic [31:0] s;
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         rd(pzsw_pkg::OFS_STAT, s);
         if (s[4] === 1'b0) break;
      end
   endtask
   task automatic click(input logic up);
      @(posedge clk);
      wheelClick <= 1'b1;
      wheelUp <= up;
      @(posedge clk);
      wheelClick <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic pin(input logic b, input logic drv, input logic lvl);
      @(posedge clk);
      if (b) begin
         drvB <= drv;
         lvlB <= lvl;
      end else begin
         drvA <= drv;
         lvlA <= lvl;
      end
      repeat (8) @(posedge clk);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      logic up;
      doReset();
      rdChk(pzsw_pkg::OFS_LOOP, 32'h0000_6464);
      rdChk(8'h3C, 32'h0);
      rnd = lfsr(rnd);
      wr(pzsw_pkg::OFS_LOOP, {16'h0, rnd[15:0]});
      wr(pzsw_pkg::OFS_CTRL, 32'h1);
      chkReg({24'h0, loopKi}, {24'h0, rnd[15:8]});
      wr(pzsw_pkg::OFS_SETPT, 32'h0000_FFFF);
      rdChk(pzsw_pkg::OFS_SETPT, 32'h2710);
      chkPin(loopClosed, 1'b1);
      wr(pzsw_pkg::OFS_CTRL, 32'h2);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         extIn <= rnd[31:16];
         sp = rnd[15:0];
         wr(pzsw_pkg::OFS_SETPT, 32'(sp));
         repeat (3) @(posedge clk);
         chkReg(32'(driveDemand), 32'(sat(sp + rnd[31:16], 65535)));
      end
      wr(pzsw_pkg::OFS_CTRL, 32'h0);
      wr(pzsw_pkg::OFS_JOG, 32'h0123);
      wr(pzsw_pkg::OFS_PRE1, 32'h1111);
      wr(pzsw_pkg::OFS_PRE2, 32'h2222);
      sp = 'h0200;
      wr(pzsw_pkg::OFS_SETPT, 32'(sp));
      for (int m = 0; m < 3; m++) begin
         for (int g = 0; g < 3; g++) begin
            for (int dn = 0; dn < 2; dn++) begin
               rnd = lfsr(rnd);
               wr(pzsw_pkg::OFS_WHEEL, {27'h0, dn[0], g[1:0], m[1:0]});
               click(rnd[0]);
               up = rnd[0] ^ dn[0];
               if (m == 2) sp = up ? 'h1111 : 'h2222;
               else sp = sat(sp + (up ? 1 : -1) *
                             (m == 1 ? 'h123 : gearMv[g]), 65535);
               rdChk(pzsw_pkg::OFS_SETPT, 32'(sp));
            end
         end
      end
      wr(pzsw_pkg::OFS_CTRL, 32'h1);
      wr(pzsw_pkg::OFS_WHEEL, 32'h01);
      wr(pzsw_pkg::OFS_SETPT, 32'd5000);
      click(1'b1);
      rdChk(pzsw_pkg::OFS_SETPT, 32'd5291);
      wr(pzsw_pkg::OFS_TRIG, 32'h0002);
      pin(0, 1'b1, 1'b0);
      pin(0, 1'b1, 1'b1);
      rdChk(pzsw_pkg::OFS_SETPT, 32'd5291);
      wr(pzsw_pkg::OFS_CTRL, 32'h0);
      wr(pzsw_pkg::OFS_TRIG, 32'h00C2);
      wr(pzsw_pkg::OFS_WSTEP, 32'h40);
      wr(pzsw_pkg::OFS_SETPT, 32'h1000);
      pin(0, 1'b1, 1'b0);
      pin(0, 1'b1, 1'b1);
      repeat (20) @(posedge clk);
      rdChk(pzsw_pkg::OFS_SETPT, 32'h1040);
      pin(0, 1'b1, 1'b0);
      pin(0, 1'b1, 1'b1);
      rdChk(pzsw_pkg::OFS_SETPT, 32'h1080);
      pin(1, 1'b1, 1'b0);
      pin(1, 1'b1, 1'b1);
      chkReg(32'(moves[0]), 32'h1);
      for (int k = 1; k < 3; k++) begin
         wr(pzsw_pkg::OFS_TRIG, 32'((k + 12) << 4));
         pin(1, 1'b1, 1'b0);
         pin(1, 1'b1, 1'b1);
         chkReg(32'(moves[k]), 32'h1);
      end
      pin(1, 1'b0, 1'b1);
      wr(pzsw_pkg::OFS_TRIG, 32'h0271);
      pin(0, 1'b0, 1'b1);
      rdChk(pzsw_pkg::OFS_STAT, {28'h0, 4'b0111});
      chkPin(trigPortBOeN, 1'b0);
      chkPin(trigPortAOeN, 1'b1);
      wr(pzsw_pkg::OFS_TRIG, 32'h0071);
      pin(0, 1'b1, 1'b0);
      chkPin(pinB, 1'b0);
      rdChk(pzsw_pkg::OFS_STAT, 32'h0);
      wr(pzsw_pkg::OFS_LOOP, 32'h2A17);
      wr(pzsw_pkg::OFS_WHEEL, 32'h11);
      wr(pzsw_pkg::OFS_CTRL, 32'h19);
      repeat (30) @(posedge clk);
      doReset();
      rdChk(pzsw_pkg::OFS_LOOP, 32'h2A17);
      rdChk(pzsw_pkg::OFS_WHEEL, 32'h11);
      rdChk(pzsw_pkg::OFS_CTRL, 32'h09);
      chkReg({30'h0, inputSel}, 32'h2);
      close_out();
   end
endmodule
bind pzsw_top pzsw_sva u_pzsw_sva (.clk, .rstn, .regAddr, .regRd, .regRdata,
   .extIn, .driveDemand, .feedbackValue, .loopClosed, .loopKp, .loopKi,
   .moveRelStart, .moveAbsStart, .moveHomeStart, .trigPortAIn, .trigPortBIn,
   .nvRd, .nvWr, .nvAddr);
